// ===== dv/seipm_host_model.sv
// Host side of the serial link: select, clock and data in
`timescale 1ns/1ns
module seipm_host_model (
    // Clock
    input  wire logic clk_i,
    // Pins towards the device
    output logic      chip_select_o,
    output logic      serial_clock_o,
    output logic      data_in_o,
    input  wire logic data_out_i,
    input  wire logic data_out_oe_n_i
);
    initial begin
        chip_select_o = 1'b0;
        serial_clock_o = 1'b0;
        data_in_o = 1'b0;
    end

    // Exactly n clocks, then nrd read clocks
    task automatic frame(input logic [28:0] v, input int n,
                         input int nrd, output logic [39:0] rd);
        rd = '0;
        @(negedge clk_i);
        chip_select_o = 1'b1;
        for (int j = 0; j < n + nrd; j++) begin
            data_in_o = (j < n) ? v[n - 1 - j] : ~data_in_o;
            repeat (4) @(negedge clk_i);
            // Long stall of the clock mid-frame
            if (j == 3) repeat (40) @(negedge clk_i);
            // No pull on the line: undriven reads inverted
            if (j >= n) rd = {rd[38:0], data_out_oe_n_i ? ~data_out_i
                                                        : data_out_i};
            // Rise with select and data settled
            serial_clock_o = 1'b1;
            repeat (4) @(negedge clk_i);
            serial_clock_o = 1'b0;
        end
        data_in_o = ~data_in_o;
        chip_select_o = 1'b0;
        repeat (10) @(negedge clk_i);
    endtask

    // Select raised after the 200 ns wait
    // No new instruction until ready shows
    task automatic status(output logic [3:0] seen);
        chip_select_o = 1'b1;
        repeat (6) @(negedge clk_i);
        seen[3:2] = {data_out_oe_n_i, data_out_i};
        for (int i = 0; i < 3000 && !data_out_oe_n_i
             && data_out_i !== 1'b1; i++) @(negedge clk_i);
        seen[1:0] = {data_out_oe_n_i, data_out_i};
        repeat (4) @(negedge clk_i);
        chip_select_o = 1'b0;
        repeat (10) @(negedge clk_i);
    endtask
endmodule

// ===== dv/seipm_port_properties.sv
// Pin-level checks of the serial instruction port
`timescale 1ns/1ns
module seipm_port_properties #(
    parameter int PROG_CYCLES = 125000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Serial link pins
    input wire logic chip_select_i,
    input wire logic serial_clock_i,
    input wire logic data_in_i,
    input wire logic data_out_o,
    input wire logic data_out_oe_n_o,
    // Configuration and status
    input wire logic width_select_i,
    input wire logic busy_o,
    input wire logic write_enabled_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // Age saturates so idle spans cost nothing
    logic sk_d;
    int   rise_age;
    int   busy_run;
    always_ff @(posedge clk_i) begin
        sk_d <= serial_clock_i;
        if (reset_i || (serial_clock_i && !sk_d)) begin
            rise_age <= 0;
        end else if (rise_age < 99) begin
            rise_age <= rise_age + 1;
        end
        busy_run <= (busy_o && !reset_i) ? busy_run + 1 : 0;
    end

    sequence s_desel;
        !chip_select_i [*7];
    endsequence
    sequence s_busy_end;
        $fell(busy_o) && chip_select_i && !data_out_oe_n_o
        ##1 chip_select_i [*3];
    endsequence

    a_reset_clears: assert property (disable iff (1'b0)
        reset_i |=> !write_enabled_o && !busy_o)
        else $error("latch or busy survived reset");
    a_latch_at_deselect: assert property (
        $changed(write_enabled_o) |-> !chip_select_i)
        else $error("write latch changed while selected");
    a_prog_needs_latch: assert property (
        $rose(busy_o) |-> write_enabled_o)
        else $error("programming started with latch clear");
    a_prog_on_deselect: assert property (
        $rose(busy_o) |-> !chip_select_i && !$past(chip_select_i))
        else $error("programming started while selected");
    a_prog_time_bound: assert property (
        busy_o |-> busy_run < PROG_CYCLES)
        else $error("programming cycle too long");
    a_release_idle: assert property (
        s_desel |-> data_out_oe_n_o)
        else $error("output driven while deselected");
    a_status_busy_low: assert property (
        busy_o && !data_out_oe_n_o |-> !data_out_o)
        else $error("status not zero while busy");
    a_status_ready: assert property (
        s_busy_end |-> data_out_o && !data_out_oe_n_o)
        else $error("ready status missing after programming");
    a_dout_on_rise: assert property (
        $changed(data_out_o) && !data_out_oe_n_o
        && !$past(data_out_oe_n_o) && !$past(busy_o)
        && !$past(busy_o, 2) && !$past(busy_o, 3)
        |-> rise_age inside {[1:4]})
        else $error("output moved away from a clock rise");
endmodule

bind seipm_port seipm_port_properties #(
    .PROG_CYCLES(PROG_CYCLES)
) u_seipm_port_properties (
    .clk_i(clk_i), .reset_i(reset_i), .chip_select_i(chip_select_i),
    .serial_clock_i(serial_clock_i), .data_in_i(data_in_i),
    .data_out_o(data_out_o), .data_out_oe_n_o(data_out_oe_n_o),
    .width_select_i(width_select_i), .busy_o(busy_o),
    .write_enabled_o(write_enabled_o)
);

// ===== dv/seipm_port_tb_top.sv
// Top of the serial instruction port testbench
`timescale 1ns/1ns
module seipm_port_tb_top;
    localparam int PROG = 2000;
    logic       clk_i;
    logic       reset_i;
    logic       width_select_i;
    logic       cs;
    logic       sk;
    logic       din;
    logic       dout;
    logic       oe_n;
    logic       busy;
    logic       wel;
    logic [39:0] rd;
    logic [3:0] st;
    int         num_errors = 0;
    int         samples_checked = 0;

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    seipm_port #(.PROG_CYCLES(PROG)) u_seipm_port (
        .clk_i(clk_i), .reset_i(reset_i), .chip_select_i(cs),
        .serial_clock_i(sk), .data_in_i(din), .data_out_o(dout),
        .data_out_oe_n_o(oe_n), .width_select_i(width_select_i),
        .busy_o(busy), .write_enabled_o(wel)
    );
    seipm_host_model u_host (
        .clk_i(clk_i), .chip_select_o(cs), .serial_clock_o(sk),
        .data_in_o(din), .data_out_i(dout), .data_out_oe_n_i(oe_n)
    );

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic fr(input logic [28:0] v, input int n, input int nrd);
        u_host.frame(v, n, nrd, rd);
    endtask

    // Programming frame, then poll the status
    task automatic prog(input logic [28:0] v, input int n);
        fr(v, n, 0);
        u_host.status(st);
        check(40'(st[3:2]), 40'h0);
        check(40'(st[1:0]), 40'h1);
        check(40'(busy), 40'h0);
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end

    initial begin
        reset_i = 1'b1;
        width_select_i = 1'b0;
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check(40'(wel), 40'h0);
        fr(29'({3'b101, 11'h3ff, 8'h11}), 22, 0);
        check(40'(busy), 40'h0);
        fr(29'({3'b100, 11'h600}), 14, 0);
        check(40'(wel), 40'h1);
        prog(29'({3'b100, 11'h200, 8'h96}), 22);
        prog(29'({3'b101, 11'h3ff, 8'h5a}), 22);
        prog(29'({3'b101, 11'h000, 8'hc3}), 22);
        fr(29'({3'b110, 11'h3ff}), 14, 25);
        check(rd, 40'({1'b0, 8'h5a, 8'hc3, 8'h96}));
        width_select_i = 1'b1;
        prog(29'({3'b101, 10'h001, 16'h1234}), 29);
        prog(29'({3'b111, 10'h000}), 13);
        fr(29'({3'b110, 10'h000}), 13, 33);
        check(rd, 40'({1'b0, 16'hffff, 16'h1234}));
        width_select_i = 1'b0;
        fr(29'({3'b110, 11'h002}), 14, 17);
        check(rd, 40'({1'b0, 8'h34, 8'h12}));
        // Short write must be dropped
        fr(29'({3'b101, 11'h005, 7'h7f}), 21, 0);
        check(40'(busy), 40'h0);
        width_select_i = 1'b1;
        fr(29'({3'b100, 10'h000}), 13, 0);
        check(40'(wel), 40'h0);
        fr(29'({3'b101, 10'h1ff, 16'h0000}), 29, 0);
        check(40'(busy), 40'h0);
        fr(29'({3'b100, 10'h300}), 13, 0);
        prog(29'({3'b100, 10'h200}), 13);
        fr(29'({3'b110, 10'h1ff}), 13, 33);
        check(rd, 40'({1'b0, 16'hffff, 16'hffff}));
        // Cycle ends with select low: no status after
        fr(29'({3'b101, 10'h005, 16'h0000}), 29, 0);
        repeat (PROG + 200) @(negedge clk_i);
        u_host.status(st);
        check(40'(st[3]), 40'h1);
        check(40'(st[1]), 40'h1);
        check(40'(wel), 40'h1);
        reset_i = 1'b1;
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check(40'(wel), 40'h0);
        give_verdict();
    end
endmodule

// ===== rtl/seipm_map.svh
// Constants of the serial instruction port: codes, sizes, timing
`ifndef SEIPM_MAP_SVH
`define SEIPM_MAP_SVH

// Clock and timing
`define SEIPM_CLK_PERIOD_NS   40
`define SEIPM_PROG_TIME_NS    5000000
`define SEIPM_PROG_CYCLES     (`SEIPM_PROG_TIME_NS / `SEIPM_CLK_PERIOD_NS)
`define SEIPM_STATUS_WAIT_NS  200
`define SEIPM_STATUS_WAIT_CYC \
    ((`SEIPM_STATUS_WAIT_NS + `SEIPM_CLK_PERIOD_NS - 1) / `SEIPM_CLK_PERIOD_NS)

// Array geometry
`define SEIPM_ARRAY_BYTES     1024
`define SEIPM_ALL_BYTES       11'h400
`define SEIPM_ALEN_X8         5'h0b
`define SEIPM_ALEN_X16        5'h0a
`define SEIPM_DLEN_X8         5'h08
`define SEIPM_DLEN_X16        5'h10
`define SEIPM_ERASED_WORD     16'hffff

// Operation codes after the start bit
`define SEIPM_OP_SPECIAL      2'h0
`define SEIPM_OP_WRITE        2'h1
`define SEIPM_OP_READ         2'h2
`define SEIPM_OP_ERASE        2'h3

// Special codes in the two top address bits
`define SEIPM_SUB_DISABLE     2'h0
`define SEIPM_SUB_FILL_ALL    2'h1
`define SEIPM_SUB_CLEAR_ALL   2'h2
`define SEIPM_SUB_ENABLE      2'h3

// Reset values
`define SEIPM_WEL_RESET       1'b0

`endif

// ===== rtl/seipm_pkg.sv
// Types of the serial instruction port
package seipm_pkg;

    typedef enum logic [1:0] {
        SEIPM_IDLE  = 2'h0,
        SEIPM_SHIFT = 2'h1,
        SEIPM_READ  = 2'h3
    } seipm_state_e;

    typedef struct packed {
        logic cs;
        logic sk;
        logic din;
        logic wsel;
    } seipm_pins_s;

    typedef struct packed {
        seipm_pins_s  meta;
        seipm_pins_s  pins;
        logic         sk_q;
        logic         cs_q;
        seipm_state_e state;
        logic [4:0]   cnt;
        logic [28:0]  sr;
        logic         x16;
        logic         wel;
        logic [9:0]   addr;
        logic [15:0]  sh;
        logic [4:0]   left;
        logic         armed;
        logic [2:0]   wait_cnt;
        logic         sweep_on;
        logic [9:0]   sweep_idx;
        logic [10:0]  sweep_left;
        logic [15:0]  pattern;
        logic         start;
        logic         dout;
        logic         oe_n;
        logic         busy;
    } seipm_regs_s;

endpackage

// ===== rtl/seipm_port.sv
// Serial instruction port of an 8 kbit non-volatile array
`timescale 1ns/1ns
`include "seipm_map.svh"

// How it works
// - 8192 bits as 1024x8 or 512x16
// - width_select high gives x16, low x8
// - Write and erase only with latch set
// - Start bit one, then opcode, address, data
// - Stopped serial clock freezes the transfer state
// - Select low ends transfer, goes standby
// - Read loads word, leads with zero bit
// - Read output moves only on serial clock rise
// - Read continues upward, wraps, ends on deselect
// - Latch clear at power-up until enable
// - Latch stays set until disable instruction or reset
// - Deselect starts timed programming if enabled
// - Programming cycle lasts at most 5 ms
// - Select high after 200 ns shows status
// - Status zero while busy, one when done
// - No status if select rises after end
// - Single ops touch one location, all-ops array
// - Opcode and special sub-code decoding
// - Non-read instructions need exact clock count
// - Clear-all sets every bit to one
module seipm_port
    import seipm_pkg::*;
#(
    parameter int PROG_CYCLES = `SEIPM_PROG_CYCLES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Serial link pins
    input  wire logic chip_select_i,
    input  wire logic serial_clock_i,
    input  wire logic data_in_i,
    output logic      data_out_o,
    output logic      data_out_oe_n_o,
    // Configuration and status
    input  wire logic width_select_i,
    output logic      busy_o,
    output logic      write_enabled_o
);

    seipm_regs_s r;
    seipm_regs_s next_r;

    logic [7:0]  mem [`SEIPM_ARRAY_BYTES];

    logic        timer_busy;
    logic        rise;
    logic        cs;
    logic        din;
    logic [4:0]  alen;
    logic [4:0]  dlen;
    logic [28:0] new_sr;
    logic [28:0] t_op;
    logic [28:0] t_top;
    logic [28:0] t_adr;
    logic [1:0]  op;
    logic [1:0]  sub;
    logic [9:0]  rd_addr;
    logic [9:0]  inc_addr;
    logic [15:0] rd_word;
    logic [7:0]  wr_byte;
    logic        do_single;
    logic        do_all;
    logic        has_data;
    logic        status_on;

    seipm_prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .start_i (r.start),
        .busy_o  (timer_busy)
    );

    always_comb begin
        if (r.x16) begin
            inc_addr = {1'b0, r.addr[8:0] + 9'h001};
        end else begin
            inc_addr = r.addr + 10'h001;
        end
    end

    always_comb begin
        if (r.state == SEIPM_SHIFT) begin
            rd_addr = r.x16 ? {1'b0, new_sr[8:0]} : new_sr[9:0];
        end else begin
            rd_addr = inc_addr;
        end
        if (r.x16) begin
            rd_word = {mem[{rd_addr[8:0], 1'b1}], mem[{rd_addr[8:0], 1'b0}]};
        end else begin
            rd_word = {mem[rd_addr], 8'h00};
        end
    end

    always_comb begin
        if (r.x16 && r.sweep_idx[0]) begin
            wr_byte = r.pattern[15:8];
        end else begin
            wr_byte = r.pattern[7:0];
        end
    end

    always_comb begin
        next_r = r;
        // Two stages before any logic looks at a pin
        next_r.meta.cs   = chip_select_i;
        next_r.meta.sk   = serial_clock_i;
        next_r.meta.din  = data_in_i;
        next_r.meta.wsel = width_select_i;
        next_r.pins      = r.meta;
        next_r.sk_q      = r.pins.sk;
        next_r.cs_q      = r.pins.cs;
        next_r.start     = 1'b0;
        next_r.busy      = timer_busy;

        rise   = r.pins.sk & ~r.sk_q;
        cs     = r.pins.cs;
        din    = r.pins.din;
        alen   = r.x16 ? `SEIPM_ALEN_X16 : `SEIPM_ALEN_X8;
        dlen   = r.x16 ? `SEIPM_DLEN_X16 : `SEIPM_DLEN_X8;
        new_sr = {r.sr[27:0], din};

        has_data = (r.cnt == 5'(5'h02 + alen + dlen));
        t_op  = r.sr >> (has_data ? 5'(alen + dlen) : alen);
        t_top = r.sr >> (has_data ? 5'(alen + dlen - 5'h02)
                                  : 5'(alen - 5'h02));
        t_adr = r.sr >> (has_data ? dlen : 5'h00);
        op    = t_op[1:0];
        sub   = t_top[1:0];
        do_single = 1'b0;
        do_all    = 1'b0;

        // sweep writes one byte a cycle
        if (r.sweep_on) begin
            next_r.sweep_idx  = r.sweep_idx + 10'h001;
            next_r.sweep_left = r.sweep_left - 11'h001;
            if (r.sweep_left == 11'h001) begin
                next_r.sweep_on = 1'b0;
            end
        end

        if (!cs) begin
            next_r.state = SEIPM_IDLE;
            next_r.cnt   = 5'h00;
            if (r.cs_q && r.state == SEIPM_SHIFT) begin
                if (r.cnt == 5'(5'h02 + alen)) begin
                    case (op)
                        `SEIPM_OP_SPECIAL: begin
                            case (sub)
                                `SEIPM_SUB_DISABLE: next_r.wel = 1'b0;
                                `SEIPM_SUB_ENABLE:  next_r.wel = 1'b1;
                                `SEIPM_SUB_CLEAR_ALL: begin
                                    do_all = 1'b1;
                                    next_r.pattern = `SEIPM_ERASED_WORD;
                                end
                                default: ;
                            endcase
                        end
                        `SEIPM_OP_ERASE: begin
                            do_single = 1'b1;
                            next_r.pattern = `SEIPM_ERASED_WORD;
                        end
                        default: ;
                    endcase
                end
                if (has_data) begin
                    if (op == `SEIPM_OP_WRITE) begin
                        do_single = 1'b1;
                        next_r.pattern = r.sr[15:0];
                    end else if (op == `SEIPM_OP_SPECIAL &&
                                 sub == `SEIPM_SUB_FILL_ALL) begin
                        do_all = 1'b1;
                        next_r.pattern = r.sr[15:0];
                    end
                end
                if (!r.wel) begin
                    do_single = 1'b0;
                    do_all    = 1'b0;
                    next_r.pattern = r.pattern;
                end
                if (do_single || do_all) begin
                    next_r.start    = 1'b1;
                    next_r.sweep_on = 1'b1;
                    next_r.armed    = 1'b1;
                    next_r.wait_cnt = 3'h0;
                    if (do_all) begin
                        next_r.sweep_idx  = 10'h000;
                        next_r.sweep_left = `SEIPM_ALL_BYTES;
                    end else if (r.x16) begin
                        next_r.sweep_idx  = {t_adr[8:0], 1'b0};
                        next_r.sweep_left = 11'h002;
                    end else begin
                        next_r.sweep_idx  = t_adr[9:0];
                        next_r.sweep_left = 11'h001;
                    end
                end
            end
        end else if (rise) begin
            case (r.state)
                SEIPM_IDLE: begin
                    // frame opens on a one
                    // Start bits while busy are dropped on purpose
                    if (din && !timer_busy && !r.start) begin
                        next_r.state = SEIPM_SHIFT;
                        next_r.cnt   = 5'h00;
                        next_r.sr    = '0;
                        next_r.armed = 1'b0;
                        next_r.x16   = r.pins.wsel;
                    end
                end
                SEIPM_SHIFT: begin
                    next_r.sr = new_sr;
                    if (r.cnt != 5'h1f) begin
                        next_r.cnt = r.cnt + 5'h01;
                    end
                    // zero bit with the last address bit
                    if (r.cnt + 5'h01 == 5'(5'h02 + alen) &&
                        new_sr[alen +: 2] == `SEIPM_OP_READ) begin
                        next_r.state = SEIPM_READ;
                        next_r.addr  = rd_addr;
                        next_r.sh    = rd_word;
                        next_r.left  = dlen;
                        next_r.dout  = 1'b0;
                    end
                end
                SEIPM_READ: begin
                    next_r.dout = r.sh[15];
                    next_r.sh   = {r.sh[14:0], 1'b0};
                    next_r.left = r.left - 5'h01;
                    if (r.left == 5'h01) begin
                        next_r.addr = inc_addr;
                        next_r.sh   = rd_word;
                        next_r.left = dlen;
                    end
                end
                default: next_r.state = SEIPM_IDLE;
            endcase
        end

        if (r.armed && r.wait_cnt != 3'(`SEIPM_STATUS_WAIT_CYC)) begin
            next_r.wait_cnt = r.wait_cnt + 3'h1;
        end
        if (r.armed && !cs && !timer_busy && !r.start && !next_r.start) begin
            next_r.armed = 1'b0;
        end

        status_on = next_r.armed && cs &&
                    r.wait_cnt == 3'(`SEIPM_STATUS_WAIT_CYC);
        // low while busy, high when done
        if (status_on) begin
            next_r.dout = !timer_busy;
        end
        next_r.oe_n = !(status_on ||
                        (next_r.state == SEIPM_READ && cs));
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r      <= '0;
            r.wel  <= `SEIPM_WEL_RESET;
            r.oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // array updated inside the timed cycle
    always_ff @(posedge clk_i) begin
        if (r.sweep_on) begin
            mem[r.sweep_idx] <= wr_byte;
        end
    end

    assign data_out_o      = r.dout;
    assign data_out_oe_n_o = r.oe_n;
    assign busy_o          = r.busy;
    assign write_enabled_o = r.wel;

endmodule

// ===== rtl/seipm_prog_timer.sv
// Self-timed programming cycle counter
`timescale 1ns/1ns
module seipm_prog_timer #(
    parameter int CYCLES = 125000
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Control
    input  wire logic start_i,
    output logic      busy_o
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
    } seipm_timer_s;

    seipm_timer_s r;
    seipm_timer_s next_r;

    always_comb begin
        next_r = r;
        if (start_i && !r.busy) begin
            next_r.busy = 1'b1;
            next_r.cnt  = CW'(CYCLES - 1);
        end else if (r.busy) begin
            if (r.cnt == '0) begin
                next_r.busy = 1'b0;
            end else begin
                next_r.cnt = r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy_o = r.busy;

endmodule
